// File: msh_strobe_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Manual display-format command raises manual flag
// - Finish or reset clears manual flag
// - First code raises strobe one
// - Finish or reset clears every strobe
// - Four codes, four strobes, four data
// - Lock suppresses all but independent codes
// - Subprogram call and return raise nothing
// - Finish already high withholds strobes
// - Code data appears with its strobe
// - Strobe drops only after finish rising or on reset
// - Strobe two needs two automatic codes
// - Strobe three needs three automatic codes
// - Strobe four needs four automatic codes
module msh_strobe_top
  import msh_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              misc_function_lock,
  input  wire logic              misc_done_1,
  input  wire logic              misc_done_2,
  input  wire logic              nc_reset_req,
  output logic                   misc_strobe_1,
  output logic                   misc_strobe_2,
  output logic                   misc_strobe_3,
  output logic                   misc_strobe_4,
  output logic      [CODE_W-1:0] misc_code_1,
  output logic      [CODE_W-1:0] misc_code_2,
  output logic      [CODE_W-1:0] misc_code_3,
  output logic      [CODE_W-1:0] misc_code_4,
  output logic                   manual_command_flag,
  output logic                   irq
);

  logic              rst_sync_b;
  msh_state_t        state;
  msh_state_t        next_state;
  logic              done_prev;
  logic [SLOTS-1:0]  strobe_q;
  logic [SLOTS-1:0]  next_strobe;
  logic [CODE_W-1:0] code_pend [SLOTS];
  logic [CODE_W-1:0] code_q    [SLOTS];
  logic [SLOTS-1:0]  fire;
  logic [SLOTS-1:0]  slot_en;
  logic [SLOTS-1:0]  wr_code;
  logic [EV_W-1:0]   irq_stat;
  logic [EV_W-1:0]   irq_mask;
  logic              next_flag;

  msh_rst_sync u_rst_sync (
    .clk        (clk),
    .rst_b      (rst_b),
    .rst_sync_b (rst_sync_b)
  );

  // Finish inputs and their rising edge
  wire done_any   = misc_done_1 || misc_done_2;
  wire done_rise  = done_any && !done_prev;
  wire reset_cond = nc_reset_req;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      done_prev <= 1'b0;
    end else begin
      done_prev <= done_any;
    end
  end

  // Register decode
  wire wr_issue = reg_wr && (reg_addr == REG_ISSUE);
  wire wr_stat  = reg_wr && (reg_addr == REG_IRQ_STAT);
  wire wr_mask  = reg_wr && (reg_addr == REG_IRQ_MASK);

  // Issue fields
  wire [CNT_W-1:0] issue_cnt   = reg_wdata[ISSUE_CNT_LSB +: CNT_W];
  wire issue_auto              = reg_wdata[ISSUE_AUTO_BIT];
  wire issue_fmt               = reg_wdata[ISSUE_FMT_BIT];
  wire issue_autostart         = reg_wdata[ISSUE_AUTOSTART_BIT];

  // A new block is taken only when idle; otherwise it is refused
  wire idle      = (state == MSH_IDLE);
  wire accept    = wr_issue && idle && !reset_cond;
  wire refused   = wr_issue && !accept;
  // Manual numerical input carries one code only
  wire [CNT_W-1:0] eff_cnt = issue_auto ? issue_cnt
                           : ((issue_cnt != '0) ? CNT_ONE : '0);
  wire any_fire  = |fire;

  genvar i;
  generate
    for (i = 0; i < SLOTS; i++) begin : g_slot
      assign wr_code[i] = reg_wr &&
        (reg_addr == REG_CODE_BASE + REG_STRIDE * ADDR_W'(i));
      assign slot_en[i] = (CNT_W'(i) < eff_cnt);

      msh_slot_gate u_gate (
        .code     (code_pend[i]),
        .slot_en  (slot_en[i]),
        .lock     (misc_function_lock),
        .done_any (done_any),
        .fire     (fire[i])
      );

      always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          code_pend[i] <= CODE_RST;
        end else if (wr_code[i]) begin
          code_pend[i] <= reg_wdata[CODE_W-1:0];
        end
      end

      // Data loads only when a block is taken, so it holds under the strobe
      always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          code_q[i] <= CODE_RST;
        end else if (accept) begin
          code_q[i] <= code_pend[i];
        end
      end
    end
  endgenerate

  // Strobe and state sequencing; reset condition has priority
  always_comb begin
    next_state  = state;
    next_strobe = strobe_q;
    if (reset_cond) begin
      next_state  = MSH_IDLE;
      next_strobe = '0;
    end else begin
      case (state)
        MSH_IDLE: begin
          if (accept && any_fire) begin
            next_strobe = fire;
            next_state  = MSH_STROBE;
          end
        end
        MSH_STROBE: begin
          if (done_rise) begin
            next_strobe = '0;
            next_state  = MSH_RELEASE;
          end
        end
        MSH_RELEASE: begin
          // Waiting for finish to drop keeps one finish from closing two blocks
          if (!done_any) begin
            next_state = MSH_IDLE;
          end
        end
        default: begin
          next_state  = MSH_IDLE;
          next_strobe = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state    <= MSH_IDLE;
      strobe_q <= '0;
    end else begin
      state    <= next_state;
      strobe_q <= next_strobe;
    end
  end

  // Manual command flag
  wire flag_set = accept && issue_fmt && !issue_autostart;
  assign next_flag = (reset_cond || done_rise) ? 1'b0
                   : (flag_set ? 1'b1 : manual_command_flag);

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      manual_command_flag <= 1'b0;
    end else begin
      manual_command_flag <= next_flag;
    end
  end

  // Outputs
  assign misc_strobe_1 = strobe_q[0];
  assign misc_strobe_2 = strobe_q[1];
  assign misc_strobe_3 = strobe_q[2];
  assign misc_strobe_4 = strobe_q[3];
  assign misc_code_1   = code_q[0];
  assign misc_code_2   = code_q[1];
  assign misc_code_3   = code_q[2];
  assign misc_code_4   = code_q[3];

  // Interrupt events; a new event in the clearing cycle survives
  wire [EV_W-1:0] ev_set;
  assign ev_set[EV_ISSUED]  = accept && any_fire;
  assign ev_set[EV_DONE]    = (state == MSH_STROBE) && done_rise && !reset_cond;
  assign ev_set[EV_REFUSED] = refused;
  assign ev_set[EV_RESET]   = reset_cond;

  wire [EV_W-1:0] ev_clr    = wr_stat ? reg_wdata[EV_W-1:0] : '0;
  wire [EV_W-1:0] next_stat = (irq_stat & ~ev_clr) | ev_set;
  wire [EV_W-1:0] next_mask = wr_mask ? reg_wdata[EV_W-1:0] : irq_mask;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_stat <= '0;
      irq_mask <= MASK_RST;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      irq_mask <= next_mask;
      irq      <= |(next_stat & next_mask);
    end
  end

  // Read path; data stands only in the cycle after the read strobe
  wire [DATA_W-1:0] state_word = DATA_W'({misc_function_lock, !idle,
                                          manual_command_flag, strobe_q});
  wire code_hit = (reg_addr < REG_ISSUE) && (reg_addr[1:0] == 2'h0);
  wire [CODE_W-1:0] code_rd = code_pend[reg_addr[3:2]];
  wire [DATA_W-1:0] rd_mux =
    code_hit                    ? DATA_W'(code_rd)  :
    (reg_addr == REG_STATE)     ? state_word        :
    (reg_addr == REG_IRQ_STAT)  ? DATA_W'(irq_stat) :
    (reg_addr == REG_IRQ_MASK)  ? DATA_W'(irq_mask) : '0;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  sequence s_finish_seen;
    done_rise && !reset_cond;
  endsequence

  sequence s_all_low;
    strobe_q == '0;
  endsequence

  a_flag_raise: assert property (
    flag_set && !reset_cond && !done_rise |=> manual_command_flag)
    else $error("manual flag not raised");

  a_flag_clear: assert property (
    done_rise || reset_cond |=> !manual_command_flag)
    else $error("manual flag not cleared");

  a_first_strobe: assert property (
    accept && fire[0] |=> misc_strobe_1 && misc_code_1 == $past(code_pend[0]))
    else $error("strobe one not raised with data");

  a_finish_clear: assert property (
    s_finish_seen |=> s_all_low)
    else $error("strobes survive finish");

  a_lock_gate: assert property (
    accept && misc_function_lock && !msh_is_independent(code_pend[0])
    |=> !misc_strobe_1)
    else $error("strobe under lock");

  a_internal_none: assert property (
    accept && msh_is_internal(code_pend[1]) |=> !misc_strobe_2)
    else $error("internal code raised a strobe");

  a_finish_high: assert property (
    accept && done_any |=> s_all_low)
    else $error("strobe raised with finish high");

  a_data_hold: assert property (
    misc_strobe_1 ##1 misc_strobe_1 |-> $stable(misc_code_1))
    else $error("code changed under strobe");

  a_wait_rise: assert property (
    (strobe_q != '0) && !done_rise && !reset_cond |=> strobe_q == $past(strobe_q))
    else $error("strobe dropped without finish");

  a_auto_only: assert property (
    accept && !issue_auto |=> !misc_strobe_2 && !misc_strobe_3 && !misc_strobe_4)
    else $error("extra strobe in manual input");

  a_count_four: assert property (
    accept && eff_cnt < 3'h4 |=> !misc_strobe_4)
    else $error("strobe four without four codes");

  a_reset_all: assert property (
    reset_cond |=> s_all_low ##0 !manual_command_flag)
    else $error("reset left strobe or flag");

  sequence s_close;
    (state == MSH_STROBE) && done_rise && !reset_cond;
  endsequence

  sequence s_finish_held;
    (state == MSH_RELEASE) && done_any && !reset_cond;
  endsequence

  a_count_two: assert property (
    accept && eff_cnt < 3'h2 |=> !misc_strobe_2)
    else $error("strobe two without two codes");

  a_count_three: assert property (
    accept && eff_cnt < 3'h3 |=> !misc_strobe_3)
    else $error("strobe three without three codes");

  a_all_four: assert property (
    accept && eff_cnt >= 3'h4 && !done_any && !misc_function_lock &&
    !msh_is_internal(code_pend[3]) |=> misc_strobe_4 && misc_code_4 == $past(code_pend[3]))
    else $error("strobe four missing");

  a_data_two: assert property (
    $rose(misc_strobe_2) |-> misc_code_2 == $past(code_pend[1]))
    else $error("code two not presented with strobe");

  a_lock_three: assert property (
    accept && misc_function_lock && !msh_is_independent(code_pend[2])
    |=> !misc_strobe_3)
    else $error("strobe three under lock");

  a_flag_hold: assert property (
    manual_command_flag && !done_rise && !reset_cond |=> manual_command_flag)
    else $error("manual flag dropped early");

  a_close_step: assert property (
    s_close |=> state == MSH_RELEASE && irq_stat[EV_DONE])
    else $error("handshake not closed");

  a_release_wait: assert property (
    s_finish_held |=> state == MSH_RELEASE)
    else $error("idle before finish dropped");

  a_strobe_source: assert property (
    $rose(misc_strobe_1) |-> $past(accept))
    else $error("strobe one without accepted block");

endmodule

// File: msh_pkg.sv
package msh_pkg;

  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int CODE_W    = 8;
  localparam int NUM_SLOTS = 4;
  localparam int CNT_W     = 3;
  localparam int EV_W      = 4;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] REG_CODE_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STRIDE    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ISSUE     = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATE     = 8'h14;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT  = 8'h18;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK  = 8'h1C;

  // Issue register fields
  localparam int ISSUE_CNT_LSB       = 0;
  localparam int ISSUE_AUTO_BIT      = 4;
  localparam int ISSUE_FMT_BIT       = 5;
  localparam int ISSUE_AUTOSTART_BIT = 6;

  // State register fields
  localparam int ST_STROBE_LSB = 0;
  localparam int ST_FLAG_BIT   = 4;
  localparam int ST_BUSY_BIT   = 5;
  localparam int ST_LOCK_BIT   = 6;

  // Event bits of the interrupt status register
  localparam int EV_ISSUED  = 0;
  localparam int EV_DONE    = 1;
  localparam int EV_REFUSED = 2;
  localparam int EV_RESET   = 3;

  // Reset values; CNT_ONE is the code count of manual input
  localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
  localparam logic [EV_W-1:0]   MASK_RST = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE  = 3'h1;

  // Special codes, binary value of the decimal code number
  localparam logic [CODE_W-1:0] M_PROG_STOP = 8'h00;
  localparam logic [CODE_W-1:0] M_OPT_STOP  = 8'h01;
  localparam logic [CODE_W-1:0] M_PROG_END  = 8'h02;
  localparam logic [CODE_W-1:0] M_END_RWD   = 8'h1E;
  localparam logic [CODE_W-1:0] M_SUB_CALL  = 8'h62;
  localparam logic [CODE_W-1:0] M_SUB_RET   = 8'h63;

  typedef enum logic [1:0] {MSH_IDLE, MSH_STROBE, MSH_RELEASE} msh_state_t;

  function automatic logic msh_is_independent(input logic [CODE_W-1:0] code);
    msh_is_independent = (code == M_PROG_STOP) || (code == M_OPT_STOP) ||
                         (code == M_PROG_END) || (code == M_END_RWD);
  endfunction

  function automatic logic msh_is_internal(input logic [CODE_W-1:0] code);
    msh_is_internal = (code == M_SUB_CALL) || (code == M_SUB_RET);
  endfunction

endpackage

// File: msh_rst_sync.sv
`timescale 1ns/1ps
module msh_rst_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  output logic      rst_sync_b
);
  logic stage1;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1     <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      stage1     <= 1'b1;
      rst_sync_b <= stage1;
    end
  end
endmodule

// File: msh_slot_gate.sv
`timescale 1ns/1ps
module msh_slot_gate
  import msh_pkg::*;
(
  input  wire logic [CODE_W-1:0] code,
  input  wire logic              slot_en,
  input  wire logic              lock,
  input  wire logic              done_any,
  output logic                   fire
);
  wire independent = msh_is_independent(code);
  wire internal    = msh_is_internal(code);
  wire lock_ok     = !lock || independent;

  // Internal codes never raise a strobe, though their data still reaches the code outputs; a high finish withholds all
  assign fire = slot_en && lock_ok && !internal && !done_any;
endmodule

// File: msh_seq_model.sv
`timescale 1ns/1ps
module msh_seq_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       en,
  input  wire logic       use_done_2,
  input  wire logic       force_done,
  input  wire logic [3:0] strobes,
  output logic            misc_done_1,
  output logic            misc_done_2
);
  logic       done;
  logic [3:0] wait_cnt;

  // Slow on purpose: the action lasts eight scans, so strobes must hold meanwhile
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done     <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (en && !done && (strobes != 4'h0)) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt == 4'h7) begin
        done <= 1'b1;
      end
    end else if (done && (strobes == 4'h0)) begin
      done     <= 1'b0;
      wait_cnt <= 4'h0;
    end
  end

  // Forced finish lets the bench present a finish that is already high
  assign misc_done_1 = (done && !use_done_2) || force_done;
  assign misc_done_2 = done && use_done_2;
endmodule

// File: msh_strobe_bench.sv
`timescale 1ns/1ps
module msh_strobe_bench
  import msh_pkg::*;
();
  logic              clk;
  logic              rst_b;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              lock;
  logic              nc_reset_req;
  logic              done_1;
  logic              done_2;
  logic              en;
  logic              use2;
  logic              force_done;
  logic [3:0]        strobes;
  logic [31:0]       codes_out;
  logic              flag;
  logic              irq;
  logic [31:0]       rdv;
  int                miscompares;
  int                checks_done;

  msh_strobe_top u_msh_strobe_top (
    .clk                 (clk),
    .rst_b               (rst_b),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .misc_function_lock  (lock),
    .misc_done_1         (done_1),
    .misc_done_2         (done_2),
    .nc_reset_req        (nc_reset_req),
    .misc_strobe_1       (strobes[0]),
    .misc_strobe_2       (strobes[1]),
    .misc_strobe_3       (strobes[2]),
    .misc_strobe_4       (strobes[3]),
    .misc_code_1         (codes_out[7:0]),
    .misc_code_2         (codes_out[15:8]),
    .misc_code_3         (codes_out[23:16]),
    .misc_code_4         (codes_out[31:24]),
    .manual_command_flag (flag),
    .irq                 (irq)
  );

  msh_seq_model u_msh_seq_model (
    .clk         (clk),
    .rst_b       (rst_b),
    .en          (en),
    .use_done_2  (use2),
    .force_done  (force_done),
    .strobes     (strobes),
    .misc_done_1 (done_1),
    .misc_done_2 (done_2)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Loads four codes, issues the block, checks flag, strobes and code data
  task automatic blk(input logic [31:0] codes, input logic [31:0] issue,
                     input logic [4:0] exp);
    int i;
    for (i = 0; i < 4; i++) begin
      wr(8'(i * 4), {24'h0, codes[i*8 +: 8]});
    end
    wr(REG_ISSUE, issue);
    #1;
    chk({27'h0, flag, strobes}, {27'h0, exp});
    chk(codes_out, codes);
  endtask

  // Waits out the handshake; code data must not move while a strobe stands
  task automatic settle();
    int          n;
    logic [31:0] held;
    n    = 0;
    held = codes_out;
    while ((strobes !== 4'h0 || done_1 !== 1'b0 || done_2 !== 1'b0) && n < 50) begin
      if (strobes !== 4'h0) begin
        chk(codes_out, held);
      end
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 50) begin
      miscompares++;
      $display("MISMATCH t=%0t handshake stuck strobes=%h", $time, strobes);
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic fin(input string name);
    $display("test %s finished, mismatches so far %0d", name, miscompares);
  endtask

  initial begin
    #100000;
    miscompares++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    rst_b        = 1'b0;
    reg_addr     = 8'h00;
    reg_wdata    = 32'h0;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    lock         = 1'b0;
    nc_reset_req = 1'b0;
    en           = 1'b1;
    use2         = 1'b0;
    force_done   = 1'b0;
    miscompares  = 0;
    checks_done  = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({27'h0, flag, strobes}, 32'h0);
    rd(REG_IRQ_MASK, rdv);
    chk(rdv, {28'h0, MASK_RST});
    rd(8'h40, rdv);
    chk(rdv, 32'h0);
    fin("reset");
    blk(32'h44332211, 32'h14, 5'h0F);
    settle();
    use2 <= 1'b1;
    blk(32'h08070605, 32'h12, 5'h03);
    settle();
    use2 <= 1'b0;
    blk(32'h0C0B0A09, 32'h13, 5'h07);
    settle();
    rd(REG_IRQ_STAT, rdv);
    chk(rdv, 32'h3);
    fin("counts");
    lock <= 1'b1;
    blk(32'h071E0205, 32'h74, 5'h06);
    rd(REG_STATE, rdv);
    chk(rdv, 32'h66);
    settle();
    lock <= 1'b0;
    blk(32'h11106362, 32'h14, 5'h0C);
    settle();
    fin("filter");
    blk(32'h0D0C0B0A, 32'h23, 5'h11);
    settle();
    chk({31'h0, flag}, 32'h0);
    force_done <= 1'b1;
    blk(32'h44332211, 32'h14, 5'h00);
    @(posedge clk);
    force_done <= 1'b0;
    settle();
    fin("manual");
    en <= 1'b0;
    wr(REG_IRQ_STAT, 32'hF);
    blk(32'h00000031, 32'h21, 5'h11);
    repeat (4) @(posedge clk);
    #1;
    chk({27'h0, flag, strobes}, 32'h11);
    wr(REG_ISSUE, 32'h21);
    #1;
    chk({27'h0, flag, strobes}, 32'h11);
    @(posedge clk);
    nc_reset_req <= 1'b1;
    @(posedge clk);
    nc_reset_req <= 1'b0;
    #1;
    chk({27'h0, flag, strobes}, 32'h0);
    rd(REG_IRQ_STAT, rdv);
    chk(rdv, 32'hD);
    wr(REG_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr(REG_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    en <= 1'b1;
    fin("reset_irq");
    stop_test();
  end
endmodule
